/* hdl/bpsc_controller.v */
// digital control of a synchronous buck converter with pwm and pulse-skipping modes
//
// Notes on behaviour
// (R1) pwm: high side on each period start
// (R2) pwm trip: high side off, low on
// (R3) pwm: low side holds until period end
// (R4) 16 zero-cross periods in row: skip
// (R5) period without zero cross clears counter
// (R6) skip pulses start on switching clock edge
// (R7) skip: high side off at 20% peak
// (R8) vout 1.5% high: off, pause switching
// (R9) vout back to nominal: resume pulses
// (R10) vout 1.5% low: back to pwm
// (R11) enable wakes reference, then soft-start
// (R12) enable low: switches off, discharge on
// (R13) overcurrent: high side off at once
// (R14) short detected: much lower switching frequency
// (R15) supply lockout acts as enable low
// (R16) thermal: shut down, restart from soft-start
// (R17) dropout: high side on at 100% (pwm only; skip mode ignores dropout)
// (R18) soft-start ramp reference only at start-up
// (R19) never both switches on; non-overlap gap
// (R20) skip: low side off at zero current
// (R21) shutdown clears counter and mode to pwm
//
// The implementer's own choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "bpsc_defines.vh"

module bpsc_controller #(
  parameter SS_CYCLES = `BPSC_SS_CYCLES
) (
  input  wire        clk_i,
  input  wire        rst_i,
  // wishbone classic slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // pins and analog comparator indications
  input  wire        enable_i,
  input  wire        pwm_trip_i,
  input  wire        zero_cross_i,
  input  wire        skip_peak_i,
  input  wire        vout_high_i,
  input  wire        vout_below_nominal_i,
  input  wire        vout_low_i,
  input  wire        overcurrent_trip_i,
  input  wire        output_short_detect_i,
  input  wire        low_supply_lockout_i,
  input  wire        thermal_shutdown_i,
  input  wire        dropout_i,
  // power stage and analog controls
  output reg         high_side_on_o,
  output reg         low_side_on_o,
  output reg         discharge_on_o,
  output reg         reference_on_o,
  output reg  [7:0]  soft_start_ramp_o,
  output reg         soft_start_active_o,
  output reg         pulse_skipping_mode_o
);

  // ----------------------------------------------------------------
  // constants
  // ----------------------------------------------------------------
  // cycle counts worked out as integers, then cut to the counter widths
  localparam integer PERIOD_I  = `BPSC_PERIOD_CYCLES;
  localparam integer SHORT_I   = `BPSC_PERIOD_CYCLES * `BPSC_SCP_DIV;
  localparam integer WAKE_I    = `BPSC_WAKE_CYCLES;
  localparam integer SS_STEP_I = (SS_CYCLES / `BPSC_RAMP_STEPS) < 1 ? 1 : (SS_CYCLES / `BPSC_RAMP_STEPS);
  localparam [7:0]  PERIOD_CYC = PERIOD_I[7:0];
  localparam [7:0]  SHORT_CYC  = SHORT_I[7:0];
  localparam [11:0] WAKE_CYC   = WAKE_I[11:0];
  localparam [19:0] SS_STEP    = SS_STEP_I[19:0];

  localparam [1:0] SUP_OFF  = 2'h0;
  localparam [1:0] SUP_WAKE = 2'h1;
  localparam [1:0] SUP_SOFT = 2'h2;
  localparam [1:0] SUP_RUN  = 2'h3;

  localparam [1:0] PH_OFF = 2'h0;
  localparam [1:0] PH_HS  = 2'h1;
  localparam [1:0] PH_LS  = 2'h2;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  reg  [11:0] sync1;
  reg  [11:0] sync2;
  wire        en_s     = sync2[0];
  wire        trip_s   = sync2[1];
  wire        zc_s     = sync2[2];
  wire        speak_s  = sync2[3];
  wire        vhigh_s  = sync2[4];
  wire        vnom_s   = sync2[5];
  wire        vlow_s   = sync2[6];
  wire        ocp_s    = sync2[7];
  wire        short_s  = sync2[8];
  wire        lock_s   = sync2[9];
  wire        therm_s  = sync2[10];
  wire        drop_s   = sync2[11];

  always @(posedge clk_i) begin
    if (rst_i) begin
      sync1 <= 12'h000;
      sync2 <= 12'h000;
    end else begin
      sync1 <= {dropout_i, thermal_shutdown_i, low_supply_lockout_i, output_short_detect_i,
                overcurrent_trip_i, vout_low_i, vout_below_nominal_i, vout_high_i,
                skip_peak_i, zero_cross_i, pwm_trip_i, enable_i};
      sync2 <= sync1;
    end
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  reg  [1:0]  ctrl;
  reg  [3:0]  dead_cfg;
  reg  [1:0]  sup_state;
  reg         skip_mode;
  reg         paused;
  reg  [4:0]  zc_count;

  wire        wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  function [31:0] bpsc_read;
    input [7:0] adr;
    begin
      bpsc_read = 32'h0000_0000;
      case (adr)
        `BPSC_REG_CTRL:     bpsc_read[1:0] = ctrl;
        `BPSC_REG_DEADTIME: bpsc_read[3:0] = dead_cfg;
        `BPSC_REG_STATUS: begin
          bpsc_read[`BPSC_ST_SUP_LSB+1:`BPSC_ST_SUP_LSB] = sup_state;
          bpsc_read[`BPSC_ST_SKIP_BIT]                   = skip_mode;
          bpsc_read[`BPSC_ST_PAUSE_BIT]                  = paused;
          bpsc_read[`BPSC_ST_ZC_LSB+4:`BPSC_ST_ZC_LSB]   = zc_count;
          bpsc_read[`BPSC_ST_HS_BIT]                     = high_side_on_o;
          bpsc_read[`BPSC_ST_LS_BIT]                     = low_side_on_o;
          bpsc_read[`BPSC_ST_SHORT_BIT]                  = short_s;
          bpsc_read[`BPSC_ST_THERM_BIT]                  = therm_s;
          bpsc_read[`BPSC_ST_LOCK_BIT]                   = lock_s;
          bpsc_read[`BPSC_ST_EN_BIT]                     = en_s;
          bpsc_read[`BPSC_ST_DROP_BIT]                   = drop_s;
        end
        default: bpsc_read = 32'h0000_0000;
      endcase
    end
  endfunction

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      ctrl     <= `BPSC_CTRL_RESET;
      dead_cfg <= `BPSC_DEAD_RESET;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? bpsc_read(wb_adr_i) : 32'h0000_0000;
      if (wb_req && wb_we_i && wb_sel_i[0]) begin
        if (wb_adr_i == `BPSC_REG_CTRL)
          ctrl <= wb_dat_i[1:0];
        if (wb_adr_i == `BPSC_REG_DEADTIME)
          dead_cfg <= wb_dat_i[3:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // switching oscillator
  // ----------------------------------------------------------------
  reg  [7:0]  osc_cnt;
  wire [7:0]  osc_last = short_s ? SHORT_CYC - 8'h01 : PERIOD_CYC - 8'h01; // [R14]
  wire        period_end = (osc_cnt >= osc_last);

  always @(posedge clk_i) begin
    if (rst_i)
      osc_cnt <= 8'h00;
    else if (period_end)
      osc_cnt <= 8'h00;
    else
      osc_cnt <= osc_cnt + 8'h01;
  end

  // ----------------------------------------------------------------
  // enable, reference wake and soft-start sequencing
  // ----------------------------------------------------------------
  reg  [11:0] wake_cnt;
  reg  [19:0] ss_pre;
  reg  [7:0]  ramp;
  wire        shutdown = ~en_s | lock_s | therm_s | ~ctrl[`BPSC_CTRL_RUN_BIT]; // [R12] [R15] [R16]
  wire        switching = (sup_state == SUP_SOFT) | (sup_state == SUP_RUN);

  always @(posedge clk_i) begin
    if (rst_i) begin
      sup_state <= SUP_OFF;
      wake_cnt  <= 12'h000;
      ss_pre    <= 20'h00000;
      ramp      <= 8'h00;
    end else if (shutdown) begin
      sup_state <= SUP_OFF;
      wake_cnt  <= 12'h000;
      ss_pre    <= 20'h00000;
      ramp      <= 8'h00;
    end else begin
      case (sup_state)
        SUP_OFF: begin
          sup_state <= SUP_WAKE; // [R11]
        end
        SUP_WAKE: begin
          if (wake_cnt >= WAKE_CYC - 12'h001)
            sup_state <= SUP_SOFT; // [R11]
          else
            wake_cnt <= wake_cnt + 12'h001;
        end
        SUP_SOFT: begin
          if (ss_pre >= SS_STEP - 20'h00001) begin
            ss_pre <= 20'h00000;
            if (ramp == 8'hff)
              sup_state <= SUP_RUN;
            else
              ramp <= ramp + 8'h01; // [R18]
          end else begin
            ss_pre <= ss_pre + 20'h00001;
          end
        end
        SUP_RUN: begin
          ramp <= 8'hff;
        end
        default: sup_state <= SUP_OFF;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // mode control: zero-cross counting and skip entry and exit
  // ----------------------------------------------------------------
  reg         zc_seen;

  always @(posedge clk_i) begin
    if (rst_i) begin
      skip_mode <= 1'b0;
      zc_count  <= 5'h00;
      zc_seen   <= 1'b0;
    end else if (!switching) begin
      skip_mode <= 1'b0; // [R21]
      zc_count  <= 5'h00; // [R21]
      zc_seen   <= 1'b0;
    end else if (skip_mode) begin
      zc_count <= 5'h00;
      zc_seen  <= 1'b0;
      if (vlow_s || ctrl[`BPSC_CTRL_FPWM_BIT])
        skip_mode <= 1'b0; // [R10]
    end else if (period_end) begin
      zc_seen <= 1'b0;
      if (zc_seen || zc_s) begin
        if (zc_count >= `BPSC_ZC_ENTRY_COUNT - 5'h01) begin
          zc_count <= 5'h00;
          skip_mode <= ~ctrl[`BPSC_CTRL_FPWM_BIT]; // [R4]
        end else begin
          zc_count <= zc_count + 5'h01; // [R4]
        end
      end else begin
        zc_count <= 5'h00; // [R5]
      end
    end else if (zc_s) begin
      zc_seen <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // switching phase within each period
  // ----------------------------------------------------------------
  reg  [1:0]  phase;

  always @(posedge clk_i) begin
    if (rst_i) begin
      phase  <= PH_OFF;
      paused <= 1'b0;
    end else if (!switching) begin
      phase  <= PH_OFF; // [R12]
      paused <= 1'b0; // [R21]
    end else if (!skip_mode) begin
      paused <= 1'b0;
      if (ocp_s) begin
        phase <= (phase == PH_HS) ? PH_LS : phase; // [R13]
      end else if (period_end) begin
        phase <= PH_HS; // [R1]
      end else if (phase == PH_HS && trip_s && !drop_s) begin
        phase <= PH_LS; // [R2]
      end else if (phase == PH_HS && drop_s) begin
        phase <= PH_HS; // [R17]
      end else if (phase == PH_LS) begin
        phase <= PH_LS; // [R3]
      end
    end else begin
      case (phase)
        PH_HS: begin
          if (vhigh_s) begin
            phase  <= PH_LS; // [R8]
            paused <= 1'b1; // [R8]
          end else if (speak_s || ocp_s) begin
            phase <= PH_LS; // [R7] [R13]
          end
        end
        PH_LS: begin
          if (zc_s)
            phase <= PH_OFF; // [R20]
          else if (period_end && !paused && !ocp_s)
            phase <= PH_HS; // [R13]
        end
        PH_OFF: begin
          if (paused && vnom_s)
            paused <= 1'b0; // [R9]
          else if (period_end && !paused && !vhigh_s && !ocp_s)
            phase <= PH_HS; // [R6] [R13]
        end
        default: phase <= PH_OFF;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // gate drive with non-overlap gap
  // ----------------------------------------------------------------
  reg  [3:0]  dead_cnt;
  wire        hs_want = switching & (phase == PH_HS);
  wire        ls_want = switching & (phase == PH_LS);
  wire        turning_off = (high_side_on_o & ~hs_want) | (low_side_on_o & ~ls_want);
  wire        gap_done = (dead_cnt == 4'h0) & ~turning_off;

  // a gate may rise only when the other is off and the gap has run out
  function bpsc_gate;
    input want;
    input self_on;
    input other_on;
    input ready;
    begin
      bpsc_gate = want & (self_on | (~other_on & ready));
    end
  endfunction

  always @(posedge clk_i) begin
    if (rst_i) begin
      high_side_on_o <= 1'b0;
      low_side_on_o  <= 1'b0;
      dead_cnt       <= 4'h0;
    end else begin
      if (turning_off)
        dead_cnt <= dead_cfg; // [R19]
      else if (dead_cnt != 4'h0)
        dead_cnt <= dead_cnt - 4'h1;
      high_side_on_o <= bpsc_gate(hs_want, high_side_on_o, low_side_on_o, gap_done); // [R19]
      low_side_on_o  <= bpsc_gate(ls_want, low_side_on_o, high_side_on_o, gap_done); // [R19]
    end
  end

  // ----------------------------------------------------------------
  // analog control outputs
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      discharge_on_o        <= 1'b1;
      reference_on_o        <= 1'b0;
      soft_start_ramp_o     <= 8'h00;
      soft_start_active_o   <= 1'b0;
      pulse_skipping_mode_o <= 1'b0;
    end else begin
      discharge_on_o        <= shutdown | (sup_state == SUP_OFF); // [R12]
      reference_on_o        <= ~shutdown & (sup_state != SUP_OFF); // [R11]
      soft_start_ramp_o     <= ramp; // [R18]
      soft_start_active_o   <= (sup_state == SUP_SOFT); // [R18]
      pulse_skipping_mode_o <= skip_mode;
    end
  end

endmodule

/* hdl/bpsc_defines.vh */
// constants for the buck pwm and pulse-skipping controller
`ifndef BPSC_DEFINES_VH
`define BPSC_DEFINES_VH

// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define BPSC_CLK_KHZ          125000
`define BPSC_SW_FREQ_KHZ      4300
`define BPSC_PERIOD_CYCLES    (`BPSC_CLK_KHZ / `BPSC_SW_FREQ_KHZ)
`define BPSC_SCP_DIV          8
`define BPSC_SS_TIME_US       1000
`define BPSC_SS_CYCLES        (`BPSC_SS_TIME_US * (`BPSC_CLK_KHZ / 1000))
`define BPSC_WAKE_TIME_US     20
`define BPSC_WAKE_CYCLES      (`BPSC_WAKE_TIME_US * (`BPSC_CLK_KHZ / 1000))
`define BPSC_ZC_ENTRY_COUNT   5'd16
`define BPSC_RAMP_STEPS       256

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define BPSC_REG_CTRL         8'h00
`define BPSC_REG_DEADTIME     8'h04
`define BPSC_REG_STATUS       8'h08

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define BPSC_CTRL_RUN_BIT     0
`define BPSC_CTRL_FPWM_BIT    1
`define BPSC_CTRL_RESET       2'h1
`define BPSC_DEAD_RESET       4'h2
`define BPSC_ST_SUP_LSB       0
`define BPSC_ST_SKIP_BIT      2
`define BPSC_ST_PAUSE_BIT     3
`define BPSC_ST_ZC_LSB        4
`define BPSC_ST_HS_BIT        9
`define BPSC_ST_LS_BIT        10
`define BPSC_ST_SHORT_BIT     11
`define BPSC_ST_THERM_BIT     12
`define BPSC_ST_LOCK_BIT      13
`define BPSC_ST_EN_BIT        14
`define BPSC_ST_DROP_BIT      15

`endif

/* testbench/bpsc_chk.sv */
// port assertions of the buck controller
`timescale 1ns/1ps
module bpsc_chk (
  input wire       clk_i,
  input wire       rst_i,
  input wire       enable_i,
  input wire       overcurrent_trip_i,
  input wire       output_short_detect_i,
  input wire       low_supply_lockout_i,
  input wire       thermal_shutdown_i,
  input wire       dropout_i,
  input wire       high_side_on_o,
  input wire       low_side_on_o,
  input wire       discharge_on_o,
  input wire       reference_on_o,
  input wire [7:0] soft_start_ramp_o,
  input wire       soft_start_active_o,
  input wire       pulse_skipping_mode_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------
  // cycles between high-side turn-ons
  // ----------------------------------------
  reg [15:0] gap;
  reg        hs_q;
  reg        sk_q;
  reg [1:0]  n_rise;
  always @(posedge clk_i) begin
    hs_q <= high_side_on_o;
    sk_q <= pulse_skipping_mode_o;
    gap  <= (high_side_on_o && !hs_q) ? 16'h1 : gap + 16'h1;
    // first pulse after a mode change still has the old offset
    if (rst_i || discharge_on_o || output_short_detect_i || pulse_skipping_mode_o != sk_q)
      n_rise <= 2'h0;
    else if (high_side_on_o && !hs_q && n_rise != 2'h3)
      n_rise <= n_rise + 2'h1;
  end
  property p_no_overlap; !(high_side_on_o && low_side_on_o); endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("gates overlap");
  property p_gap; $fell(high_side_on_o) |-> !low_side_on_o [*2]; endproperty
  a_gap: assert property (p_gap) else $error("no gap");
  property p_period; $rose(high_side_on_o) && n_rise >= 2'h2 |-> gap % 16'd29 == 16'd0; endproperty
  a_period: assert property (p_period) else $error("off clock");
  property p_en_off; !enable_i [*6] |-> discharge_on_o && !high_side_on_o && !low_side_on_o; endproperty
  a_en_off: assert property (p_en_off) else $error("not off");
  property p_lock; low_supply_lockout_i [*6] |-> discharge_on_o && !high_side_on_o; endproperty
  a_lock: assert property (p_lock) else $error("lockout");
  property p_therm; thermal_shutdown_i [*6] |-> discharge_on_o && !high_side_on_o; endproperty
  a_therm: assert property (p_therm) else $error("thermal");
  property p_ocp; overcurrent_trip_i [*6] |-> !high_side_on_o; endproperty
  a_ocp: assert property (p_ocp) else $error("overcurrent");
  property p_drop; (dropout_i && !overcurrent_trip_i && !pulse_skipping_mode_o && !discharge_on_o
    && !soft_start_active_o) [*8] |-> !$fell(high_side_on_o); endproperty
  a_drop: assert property (p_drop) else $error("dropout");
  property p_ref; $rose(soft_start_active_o) |-> $past(reference_on_o, 2); endproperty
  a_ref: assert property (p_ref) else $error("reference late");
  property p_ramp; soft_start_active_o && $past(soft_start_active_o)
    |-> soft_start_ramp_o >= $past(soft_start_ramp_o); endproperty
  a_ramp: assert property (p_ramp) else $error("ramp fell");
  property p_ss_pwm; $rose(soft_start_active_o) |-> !pulse_skipping_mode_o; endproperty
  a_ss_pwm: assert property (p_ss_pwm) else $error("skip at start");
endmodule

/* testbench/bpsc_stage_model.sv */
// comparator model: trips after dly_i cycles of high side, zero cross while low side on
`timescale 1ns/1ps
module bpsc_stage_model (
  input  wire       clk_i,
  input  wire       hs_i,
  input  wire       ls_i,
  input  wire [4:0] dly_i,
  input  wire       zc_en_i,
  output reg        trip_o,
  output reg        peak_o,
  output reg        zc_o
);
  reg [4:0] n_on;
  always @(posedge clk_i) begin
    n_on   <= hs_i ? n_on + 5'h1 : 5'h0;
    trip_o <= hs_i && n_on >= dly_i;
    peak_o <= hs_i && n_on >= dly_i;
    zc_o   <= zc_en_i && ls_i;
  end
endmodule

/* testbench/test_buck_pwm_skip_controller.sv */
// self-checking bench of the buck controller
`timescale 1ns/1ps
`include "bpsc_defines.vh"
`define CHK(g, e) begin n_compared = n_compared + 1; if ((g) !== (e)) begin \
  n_errors = n_errors + 1; $display("ERROR %0t got %h exp %h", $time, g, e); end end
module test_buck_pwm_skip_controller;
  reg         clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, enable_i, vout_high_i, vout_below_nominal_i;
  reg         vout_low_i, overcurrent_trip_i, output_short_detect_i, low_supply_lockout_i;
  reg         thermal_shutdown_i, dropout_i, zc_en;
  reg  [7:0]  wb_adr_i;
  reg  [3:0]  wb_sel_i;
  reg  [31:0] wb_dat_i, rd;
  reg  [4:0]  dly;
  wire [31:0] wb_dat_o;
  wire [7:0]  soft_start_ramp_o;
  wire        wb_ack_o, pwm_trip_i, zero_cross_i, skip_peak_i, high_side_on_o, low_side_on_o;
  wire        discharge_on_o, reference_on_o, soft_start_active_o, pulse_skipping_mode_o;
  integer     n_errors, n_compared, t, c, dt;
  bpsc_controller #(.SS_CYCLES(512)) i_bpsc_controller (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .enable_i, .pwm_trip_i, .zero_cross_i,
    .skip_peak_i, .vout_high_i, .vout_below_nominal_i, .vout_low_i, .overcurrent_trip_i,
    .output_short_detect_i, .low_supply_lockout_i, .thermal_shutdown_i, .dropout_i, .high_side_on_o,
    .low_side_on_o, .discharge_on_o, .reference_on_o, .soft_start_ramp_o, .soft_start_active_o,
    .pulse_skipping_mode_o);
  bpsc_stage_model i_bpsc_stage_model (.clk_i, .hs_i(high_side_on_o), .ls_i(low_side_on_o), .dly_i(dly),
    .zc_en_i(zc_en), .trip_o(pwm_trip_i), .peak_o(skip_peak_i), .zc_o(zero_cross_i));
  // ----------------------------------------
  // bus cycle, waits and verdict
  // ----------------------------------------
  task wb(input w, input [7:0] a, input [31:0] d);
    begin
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1) @(posedge clk_i);
      rd = wb_dat_o;
      `CHK(wb_ack_o, 1'b1)
      {wb_cyc_i, wb_stb_i} <= 2'b00;
      @(posedge clk_i);
    end
  endtask
  task rise;
    begin
      for (c = 0; high_side_on_o === 1'b1 && c < 3000; c = c + 1) @(posedge clk_i);
      for (c = c; high_side_on_o !== 1'b1 && c < 3000; c = c + 1) @(posedge clk_i);
    end
  endtask
  task boot;
    begin
      repeat (10) @(posedge clk_i);
      `CHK({reference_on_o, soft_start_active_o}, 2'b10)
      for (t = 0; soft_start_active_o !== 1'b1 && t < 4000; t = t + 1) @(posedge clk_i);
      `CHK(soft_start_active_o, 1'b1)
      for (t = 0; soft_start_active_o === 1'b1 && t < 2000; t = t + 1) @(posedge clk_i);
      `CHK(soft_start_ramp_o, 8'hff)
    end
  endtask
  function integer exp_period(input output_short_detect);
    begin
      exp_period = output_short_detect ? `BPSC_SCP_DIV * `BPSC_PERIOD_CYCLES : `BPSC_PERIOD_CYCLES;
    end
  endfunction
  task print_verdict;
    begin
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  initial begin
    #400000;
    n_errors = n_errors + 1;
    print_verdict;
  end
  initial begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, enable_i, vout_high_i, vout_below_nominal_i, vout_low_i} = 8'h80;
    {overcurrent_trip_i, output_short_detect_i, low_supply_lockout_i, thermal_shutdown_i} = 4'h0;
    {dropout_i, zc_en, wb_adr_i, wb_sel_i, wb_dat_i, dly} = {2'b00, 8'h00, 4'hf, 32'h0, 5'h4};
    n_errors = 0;
    n_compared = 0;
    dt = $urandom(76270);
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, `BPSC_REG_CTRL, 32'h0);
    `CHK(rd, 32'h1)
    wb(1'b0, `BPSC_REG_DEADTIME, 32'h0);
    `CHK(rd, 32'h2)
    wb(1'b1, 8'h0c, 32'hffffffff);
    wb(1'b0, 8'h0c, 32'h0);
    `CHK(rd, 32'h0)
    dt = 2 + $urandom % 4;
    wb(1'b1, `BPSC_REG_DEADTIME, dt[31:0]);
    wb(1'b0, `BPSC_REG_DEADTIME, 32'h0);
    `CHK(rd[3:0], dt[3:0])
    `CHK({discharge_on_o, high_side_on_o, low_side_on_o}, 3'b100)
    enable_i <= 1'b1;
    boot;
    wb(1'b0, `BPSC_REG_STATUS, 32'h0);
    `CHK(rd[1:0], 2'h3)
    $display("test start-up done");
    dly <= 5'd3 + $urandom % 6;
    rise;
    rise;
    `CHK(c, exp_period(1'b0))
    for (t = 0; low_side_on_o !== 1'b1 && t < 29; t = t + 1) @(posedge clk_i);
    `CHK({high_side_on_o, low_side_on_o}, 2'b01)
    for (t = 0; low_side_on_o === 1'b1 && t < 40; t = t + 1) @(posedge clk_i);
    for (c = 0; high_side_on_o !== 1'b1 && c < 40; c = c + 1) @(posedge clk_i);
    `CHK(c <= dt + 3, 1'b1)
    dly <= 5'd31;
    rise;
    overcurrent_trip_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    `CHK(high_side_on_o, 1'b0)
    {overcurrent_trip_i, dropout_i, dly} <= {2'b01, 5'd4};
    repeat (40) @(posedge clk_i);
    `CHK(high_side_on_o, 1'b1)
    repeat (50) @(posedge clk_i);
    `CHK(high_side_on_o, 1'b1)
    {dropout_i, zc_en} <= 2'b01;
    $display("test pwm done");
    repeat ((4 + $urandom % 10) * 29) @(posedge clk_i);
    zc_en <= 1'b0;
    repeat (3 * 29) @(posedge clk_i);
    wb(1'b0, `BPSC_REG_STATUS, 32'h0);
    `CHK(rd[8:2], 7'h0)
    zc_en <= 1'b1;
    repeat (14 * 29) @(posedge clk_i);
    `CHK(pulse_skipping_mode_o, 1'b0)
    for (t = 0; pulse_skipping_mode_o !== 1'b1 && t < 5 * 29; t = t + 1) @(posedge clk_i);
    `CHK(pulse_skipping_mode_o, 1'b1)
    dly <= 5'd2;
    rise;
    for (c = 0; high_side_on_o === 1'b1 && c < 29; c = c + 1) @(posedge clk_i);
    `CHK(c <= 10, 1'b1)
    dly <= 5'd31;
    rise;
    vout_high_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    `CHK(high_side_on_o, 1'b0)
    for (t = 0; high_side_on_o !== 1'b1 && t < 100; t = t + 1) @(posedge clk_i);
    `CHK(t, 100)
    `CHK(low_side_on_o, 1'b0)
    wb(1'b0, `BPSC_REG_STATUS, 32'h0);
    `CHK(rd[3:2], 2'b11)
    {vout_high_i, vout_below_nominal_i, dly} <= {2'b01, 5'd2};
    for (t = 0; high_side_on_o !== 1'b1 && t < 2 * 29 + 8; t = t + 1) @(posedge clk_i);
    `CHK(high_side_on_o, 1'b1)
    {vout_below_nominal_i, low_supply_lockout_i} <= 2'b01;
    $display("test skip done");
    repeat (8) @(posedge clk_i);
    `CHK({discharge_on_o, high_side_on_o, low_side_on_o}, 3'b100)
    `CHK(pulse_skipping_mode_o, 1'b0)
    wb(1'b0, `BPSC_REG_STATUS, 32'h0);
    `CHK({rd[8:4], rd[2:0]}, 8'h0)
    low_supply_lockout_i <= 1'b0;
    boot;
    for (t = 0; pulse_skipping_mode_o !== 1'b1 && t < 20 * 29; t = t + 1) @(posedge clk_i);
    `CHK(pulse_skipping_mode_o, 1'b1)
    wb(1'b1, `BPSC_REG_CTRL, 32'h3);
    repeat (4) @(posedge clk_i);
    `CHK(pulse_skipping_mode_o, 1'b0)
    wb(1'b1, `BPSC_REG_CTRL, 32'h1);
    for (t = 0; pulse_skipping_mode_o !== 1'b1 && t < 20 * 29; t = t + 1) @(posedge clk_i);
    `CHK(pulse_skipping_mode_o, 1'b1)
    {zc_en, vout_low_i} <= 2'b01;
    repeat (8) @(posedge clk_i);
    `CHK(pulse_skipping_mode_o, 1'b0)
    {vout_low_i, output_short_detect_i} <= 2'b01;
    rise;
    rise;
    rise;
    `CHK(c, exp_period(1'b1))
    thermal_shutdown_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    `CHK({discharge_on_o, high_side_on_o, low_side_on_o}, 3'b100)
    {thermal_shutdown_i, output_short_detect_i} <= 2'b00;
    boot;
    wb(1'b1, `BPSC_REG_CTRL, 32'h0);
    repeat (4) @(posedge clk_i);
    `CHK({discharge_on_o, high_side_on_o, low_side_on_o}, 3'b100)
    wb(1'b1, `BPSC_REG_CTRL, 32'h1);
    boot;
    enable_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    `CHK({discharge_on_o, high_side_on_o, low_side_on_o}, 3'b100)
    $display("test shutdown done");
    print_verdict;
  end
endmodule
bind bpsc_controller bpsc_chk i_bpsc_chk (.clk_i, .rst_i, .enable_i, .overcurrent_trip_i, .output_short_detect_i,
  .low_supply_lockout_i, .thermal_shutdown_i, .dropout_i, .high_side_on_o, .low_side_on_o, .discharge_on_o,
  .reference_on_o, .soft_start_ramp_o, .soft_start_active_o, .pulse_skipping_mode_o);
